// >>> src/capture_compare_unit.sv
// Capture/compare unit: registers, prescaler, capture, compare
//
// Behaviour
// - Capture event change may raise a false flag
// - Four capture prescaler settings via mode field
// - Prescaler held zero when off or not capturing
// - Every reset clears the prescaler counter
// - Switching prescalers keeps counter, may flag falsely
// - Instruction-clocked timer halts in sleep, then resumes
// - Externally clocked timer keeps capture working asleep
// - Compare value continuously against timer count
// - Match toggles, sets, clears pin, or triggers
// - Every compare match sets the interrupt flag
// - Capture codes: fall, rise, fourth, sixteenth rise
// - Compare codes: toggle, set, clear, flag, trigger
// - Capture copies timer count and sets flag
// - Special trigger resets timer, second unit starts conversion
//
// Implementation choices: the placing of the registers and the strobed register port.
`default_nettype none
module capture_compare_unit #(
  parameter bit IS_SECOND_UNIT = 1'b0
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rd_data,
  input  wire logic [1:0] i_unit_pin,
  output logic            o_unit_pin_out,
  output logic      [1:0] o_unit_pin_oe,
  input  wire logic       i_timer_ext_clk,
  input  wire logic       i_sleep,
  input  wire logic       i_adc_enabled,
  output logic            o_special_event,
  output logic            o_adc_start,
  output logic            o_irq_flag,
  output logic            o_irq_request
);
  typedef struct packed {
    logic [3:0]  mode;     // unit_mode_select
    logic [1:0]  duty;     // duty_low_bits, stored only
    logic [15:0] value;    // capture_compare_value
    logic        irq_en;   // capture_compare_irq_enable
    logic        irq_flag; // capture_compare_irq_flag
    logic        pin_sel;  // second_unit_pin_select
    logic        tmr_on;   // Timer run
    logic        tmr_ext;  // Timer external source
    logic [4:0]  presc;    // Capture prescaler counter
    logic        pin_out;  // Compare output latch
    logic        match_d;  // Match seen last cycle
    logic        special;  // Special event pulse
    logic        adc;      // Conversion start pulse
    logic [7:0]  rd_data;  // Read answer
  } state_t;
  state_t r;
  state_t n;

  pin_event_if pe ();
  logic [15:0] tcount;     // Timer count
  logic        capturing;  // Mode is a capture mode
  logic        scaled;     // Mode uses the prescaler
  logic        comparing;  // Mode is a compare mode
  logic        pin_mode;   // Compare mode that drives the pin
  logic        match;      // Value equals timer count
  logic        hit;        // First cycle of a match
  logic        cap_evt;    // Selected capture event
  logic [4:0]  presc_div;  // Selected prescaler count
  logic [4:0]  presc_inc;  // Prescaler plus one rise

  // Pin synchroniser and edge detector
  pin_edge_sync #(
    .N (2)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_pins    (i_unit_pin),
    .i_select  (r.pin_sel),
    .evt       (pe.src)
  );

  // Shared time base
  timer_one_counter #(
    .DIV (cc_pkg::INSTR_DIV)
  ) u_timer (
    .i_clk_sys    (i_clk_sys),
    .i_rst_n      (i_rst_n),
    .i_enable     (r.tmr_on),
    .i_ext_source (r.tmr_ext),
    .i_sleep      (i_sleep),
    .i_ext_clk    (i_timer_ext_clk),
    .i_clear_req  (match && r.mode == cc_pkg::MODE_SPECIAL),
    .o_count      (tcount)
  );

  // Mode decode
  always_comb begin
    capturing = (r.mode[3:2] == 2'b01);
    scaled    = (r.mode == cc_pkg::MODE_RISE4) || (r.mode == cc_pkg::MODE_RISE16);
    presc_div = (r.mode == cc_pkg::MODE_RISE16) ? cc_pkg::PRESC_16 : cc_pkg::PRESC_4;
    presc_inc = r.presc + 5'h01;
    pin_mode  = (r.mode == cc_pkg::MODE_TOGGLE) || (r.mode == cc_pkg::MODE_SET)
             || (r.mode == cc_pkg::MODE_CLEAR);
    comparing = pin_mode || (r.mode == cc_pkg::MODE_SWI) || (r.mode == cc_pkg::MODE_SPECIAL);
    match     = comparing && (r.value == tcount);
    hit       = match && !r.match_d;
  end

  // Capture event select
  always_comb begin
    unique case (r.mode)
      cc_pkg::MODE_FALL:   cap_evt = pe.fall;
      cc_pkg::MODE_RISE:   cap_evt = pe.rise;
      cc_pkg::MODE_RISE4,
      cc_pkg::MODE_RISE16: cap_evt = pe.rise && (presc_inc >= presc_div);
      default:             cap_evt = 1'b0;
    endcase
  end

  // Next state: registers, prescaler, capture and compare actions
  always_comb begin
    n         = r;
    n.rd_data = 8'h00;
    n.match_d = match;
    n.special = hit && (r.mode == cc_pkg::MODE_SPECIAL);
    n.adc     = n.special && IS_SECOND_UNIT && i_adc_enabled;
    // Prescaler
    if (!capturing) begin
      n.presc = 5'h00;
    end else if (scaled && pe.rise) begin
      n.presc = cap_evt ? 5'h00 : presc_inc;
    end
    // Software writes
    if (i_wr) begin
      unique case (i_addr)
        cc_pkg::OFF_CTRL: begin
          n.mode = i_wr_data[cc_pkg::MODE_LSB +: 4];
          n.duty = i_wr_data[cc_pkg::DUTY_LSB +: 2];
        end
        cc_pkg::OFF_VALUE_LO: n.value[7:0]  = i_wr_data;
        cc_pkg::OFF_VALUE_HI: n.value[15:8] = i_wr_data;
        cc_pkg::OFF_IRQ_EN:   n.irq_en      = i_wr_data[0];
        cc_pkg::OFF_IRQ_FLAG: n.irq_flag    = i_wr_data[0];
        cc_pkg::OFF_PIN_SEL:  n.pin_sel     = i_wr_data[0];
        cc_pkg::OFF_TMR_CTRL: begin
          n.tmr_on  = i_wr_data[cc_pkg::TMR_ON];
          n.tmr_ext = i_wr_data[cc_pkg::TMR_EXT];
        end
        default: ;
      endcase
    end
    // Capture overrides a same-cycle value write
    if (cap_evt) begin
      n.value    = tcount;
      n.irq_flag = 1'b1;
    end
    // Compare match actions
    if (hit) begin
      n.irq_flag = 1'b1;
      unique case (r.mode)
        cc_pkg::MODE_TOGGLE: n.pin_out = ~r.pin_out;
        cc_pkg::MODE_SET:    n.pin_out = 1'b1;
        cc_pkg::MODE_CLEAR:  n.pin_out = 1'b0;
        default: ;
      endcase
    end
    // Off forces the output latch low
    if (r.mode == cc_pkg::MODE_OFF) begin
      n.pin_out = 1'b0;
    end
    // Read answer, one cycle later
    if (i_rd) begin
      unique case (i_addr)
        cc_pkg::OFF_CTRL:     n.rd_data = {2'b00, r.duty, r.mode};
        cc_pkg::OFF_VALUE_LO: n.rd_data = r.value[7:0];
        cc_pkg::OFF_VALUE_HI: n.rd_data = r.value[15:8];
        cc_pkg::OFF_IRQ_EN:   n.rd_data = {7'h00, r.irq_en};
        cc_pkg::OFF_IRQ_FLAG: n.rd_data = {7'h00, r.irq_flag};
        cc_pkg::OFF_PIN_SEL:  n.rd_data = {7'h00, r.pin_sel};
        cc_pkg::OFF_TMR_CTRL: n.rd_data = {6'h00, r.tmr_ext, r.tmr_on};
        cc_pkg::OFF_TMR_LO:   n.rd_data = tcount[7:0];
        cc_pkg::OFF_TMR_HI:   n.rd_data = tcount[15:8];
        default:              n.rd_data = 8'h00;
      endcase
    end
  end

  // State register, synchronous reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      r       <= '0;
      r.mode  <= cc_pkg::CTRL_RESET[3:0];
      r.value <= cc_pkg::VALUE_RESET;
    end else begin
      r <= n;
    end
  end

  // Outputs
  assign o_rd_data       = r.rd_data;
  assign o_unit_pin_out  = r.pin_out;
  assign o_unit_pin_oe   = pin_mode ? (r.pin_sel ? 2'b10 : 2'b01) : 2'b00;
  assign o_special_event = r.special;
  assign o_adc_start     = r.adc;
  assign o_irq_flag      = r.irq_flag;
  assign o_irq_request   = r.irq_flag & r.irq_en;

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_special_hit;
    hit && r.mode == cc_pkg::MODE_SPECIAL;
  endsequence
  sequence s_one_pulse;
    o_special_event ##1 !o_special_event;
  endsequence
  // Rising edge seen while counting to sixteen
  sequence s_rise16;
    r.mode == cc_pkg::MODE_RISE16 && pe.rise;
  endsequence
  // Own disable, so the check still runs while reset is held
  property p_reset_clears;
    @(posedge i_clk_sys) disable iff (1'b0) !i_rst_n |=> r.presc == 5'h00 && !r.irq_flag;
  endproperty

  AST_PRESC_IDLE: assert property (!capturing |=> r.presc == 5'h00)
    else $error("Prescaler not held at zero outside capture");
  AST_PRESC_KEEP: assert property (scaled && !pe.rise |=> r.presc == $past(r.presc))
    else $error("Prescaler changed without a rising edge");
  AST_PRESC_16: assert property (s_rise16 |=> (r.presc == 5'h00) == ($past(r.presc) == 5'h0f))
    else $error("Sixteenth-edge prescaler wrapped at the wrong count");
  AST_CAPTURE: assert property (cap_evt |=> r.value == $past(tcount) && r.irq_flag)
    else $error("Capture did not latch the timer count");
  AST_MATCH_FLAG: assert property (hit |=> r.irq_flag)
    else $error("Compare match did not set the flag");
  AST_TOGGLE: assert property (hit && r.mode == cc_pkg::MODE_TOGGLE |=> o_unit_pin_out != $past(o_unit_pin_out))
    else $error("Toggle mode did not toggle the pin");
  AST_SWI_PIN: assert property (r.mode == cc_pkg::MODE_SWI |-> o_unit_pin_oe == 2'b00)
    else $error("Flag-only mode drives the pin");
  AST_SPECIAL: assert property (s_special_hit |=> s_one_pulse)
    else $error("Special event not a single pulse after match");
  AST_MATCH: assert property (comparing && r.value == tcount && !r.match_d |=> r.irq_flag)
    else $error("Equal value and count not detected");
  AST_RESET: assert property (p_reset_clears)
    else $error("Reset left prescaler or flag set");
endmodule
`default_nettype wire

// >>> include/cc_pkg.sv
// Constants shared by the capture/compare unit and its helpers
`default_nettype none
package cc_pkg;
  // Register offsets (byte addresses on the 8-bit register port)
  localparam logic [3:0] OFF_CTRL      = 4'h0;  // Unit control: duty_low_bits, unit_mode_select
  localparam logic [3:0] OFF_VALUE_LO  = 4'h1;  // Capture/compare value, low byte
  localparam logic [3:0] OFF_VALUE_HI  = 4'h2;  // Capture/compare value, high byte
  localparam logic [3:0] OFF_IRQ_EN    = 4'h3;  // Interrupt enable
  localparam logic [3:0] OFF_IRQ_FLAG  = 4'h4;  // Interrupt flag
  localparam logic [3:0] OFF_PIN_SEL   = 4'h5;  // Alternate pin select
  localparam logic [3:0] OFF_TMR_CTRL  = 4'h6;  // Timer on and clock source
  localparam logic [3:0] OFF_TMR_LO    = 4'h7;  // Timer count, low byte, read only
  localparam logic [3:0] OFF_TMR_HI    = 4'h8;  // Timer count, high byte, read only
  // Field positions
  localparam int MODE_LSB  = 0;  // unit_mode_select lsb
  localparam int DUTY_LSB  = 4;  // duty_low_bits lsb
  localparam int TMR_ON    = 0;  // Timer run bit
  localparam int TMR_EXT   = 1;  // Timer external clock source bit
  // Reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  // Mode codes of unit_mode_select
  localparam logic [3:0] MODE_OFF     = 4'h0;  // Off, unit reset
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;  // Compare, toggle pin
  localparam logic [3:0] MODE_FALL    = 4'h4;  // Capture every falling edge
  localparam logic [3:0] MODE_RISE    = 4'h5;  // Capture every rising edge
  localparam logic [3:0] MODE_RISE4   = 4'h6;  // Capture every 4th rising edge
  localparam logic [3:0] MODE_RISE16  = 4'h7;  // Capture every 16th rising edge
  localparam logic [3:0] MODE_SET     = 4'h8;  // Compare, set pin
  localparam logic [3:0] MODE_CLEAR   = 4'h9;  // Compare, clear pin
  localparam logic [3:0] MODE_SWI     = 4'ha;  // Compare, flag only
  localparam logic [3:0] MODE_SPECIAL = 4'hb;  // Compare, special event trigger
  // Prescaler counts and instruction clock divider
  localparam logic [4:0] PRESC_4      = 5'h04;
  localparam logic [4:0] PRESC_16     = 5'h10;
  localparam int         INSTR_DIV    = 4;     // Instruction clock is system clock over four
endpackage
`default_nettype wire

// >>> include/pin_event_if.sv
// Edge events of the selected unit pin
`default_nettype none
interface pin_event_if;
  logic rise;   // One-cycle pulse on a rising edge
  logic fall;   // One-cycle pulse on a falling edge
  logic level;  // Synchronised pin level
  modport src (output rise, output fall, output level);
  modport dst (input rise, input fall, input level);
endinterface
`default_nettype wire

// >>> src/pin_edge_sync.sv
// Two-stage pin synchroniser, pin select and edge detector
`default_nettype none
module pin_edge_sync #(
  parameter int N = 2
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  input  wire logic [N-1:0] i_pins,
  input  wire logic         i_select,
  pin_event_if.src          evt
);
  typedef struct packed {
    logic [N-1:0] s1;    // First stage, read only by s2
    logic [N-1:0] s2;    // Second stage
    logic         prev;  // Last selected level
  } state_t;
  state_t r;
  state_t n;
  logic   sel_lvl;  // Selected synchronised level

  // Select one synchronised pin
  assign sel_lvl = r.s2[i_select];

  // Next state of the sync chain
  always_comb begin
    n      = r;
    n.s1   = i_pins;
    n.s2   = r.s1;
    n.prev = sel_lvl;
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // One pulse per edge
  assign evt.rise  = sel_lvl & ~r.prev;
  assign evt.fall  = ~sel_lvl & r.prev;
  assign evt.level = sel_lvl;
endmodule
`default_nettype wire

// >>> src/timer_one_counter.sv
// Sixteen-bit time base with instruction or external clock
`default_nettype none
module timer_one_counter #(
  parameter int DIV = cc_pkg::INSTR_DIV
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_enable,
  input  wire logic        i_ext_source,
  input  wire logic        i_sleep,
  input  wire logic        i_ext_clk,
  input  wire logic        i_clear_req,
  output logic      [15:0] o_count
);
  typedef struct packed {
    logic        s1;     // External clock, first stage
    logic        s2;     // External clock, second stage
    logic        prev;   // Last synchronised level
    logic [1:0]  div;    // Instruction clock divider
    logic [15:0] count;  // Timer count
  } state_t;
  state_t r;
  state_t n;
  logic   tick;  // One timer increment

  // Divider, external edge and count
  always_comb begin
    n      = r;
    tick   = 1'b0;
    n.s1   = i_ext_clk;
    n.s2   = r.s1;
    n.prev = r.s2;
    if (i_ext_source) begin
      tick = i_enable & r.s2 & ~r.prev;
    end else if (!i_sleep) begin
      n.div = (r.div == 2'(DIV - 1)) ? 2'h0 : r.div + 2'h1;
      tick  = i_enable & (r.div == 2'(DIV - 1));
    end
    if (tick) begin
      n.count = i_clear_req ? 16'h0000 : r.count + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_count = r.count;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  AST_SLEEP_HOLD: assert property (i_enable && !i_ext_source && i_sleep |=> o_count == $past(o_count))
    else $error("Timer advanced during sleep on instruction clock");
endmodule
`default_nettype wire

// >>> tb/pin_event_model.sv
// Far-side model: events on the unit pins and an external timer clock
`default_nettype none
module pin_event_model (
  input  wire logic       i_clk_sys,
  output logic      [1:0] o_pins,
  output logic            o_ext_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl;  // Level on the default pin
  // Alternate pin carries the inverse, so a wrong pick misfires
  assign o_pins = {~lvl, lvl};
  // Quiet pin and still clock at start
  initial begin
    lvl = 1'b0;
    o_ext_clk = 1'b0;
  end
  // Set one level and hold it well past the synchroniser
  task automatic drive(input logic val);
    lvl <= val;
    repeat (5) @(posedge i_clk_sys);
  endtask
  // Full low-high pairs, one rising edge each
  task automatic rises(input int n);
    for (int k = 0; k < n; k++) begin
      drive(1'b0);
      drive(1'b1);
    end
  endtask
  // External source pulses, still between bursts
  task automatic ext_pulses(input int n);
    for (int k = 0; k < n; k++) begin
      o_ext_clk <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      o_ext_clk <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/test_capture_compare_unit.sv
// Self-checking bench for the capture/compare unit
`default_nettype none
module test_capture_compare_unit;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_t;  // Write, expected readback
  typedef struct packed {logic [3:0] m; logic [4:0] n;} cap_t;               // Mode, edges to one event
  typedef struct packed {logic [3:0] m; logic [2:0] e;} cmp_t;               // Mode, pin level and enables
  logic        clk_sys, rst_n, wr, rd, sleep, ext_clk, pin_out, special, adc_start, irq_flag, irq_req, adc_en;
  logic [3:0]  addr;
  logic [7:0]  wr_data, rd_data, b;
  logic [1:0]  pins, pin_oe;
  logic [15:0] c, d, v;
  int          failures = 0, cmp_count = 0, spec_cnt = 0, adc_cnt = 0;
  row_t rows [10] = '{'{4'h0, 8'hff, 8'h3f}, '{4'h0, 8'h00, 8'h00}, '{4'h1, 8'ha5, 8'ha5},
    '{4'h2, 8'h5a, 8'h5a}, '{4'h3, 8'hff, 8'h01}, '{4'h3, 8'h00, 8'h00}, '{4'h4, 8'h00, 8'h00},
    '{4'h5, 8'h00, 8'h00}, '{4'h7, 8'hff, 8'h00}, '{4'h9, 8'hff, 8'h00}};
  cap_t caps [4] = '{'{cc_pkg::MODE_FALL, 5'h02}, '{cc_pkg::MODE_RISE, 5'h01},
    '{cc_pkg::MODE_RISE4, 5'h04}, '{cc_pkg::MODE_RISE16, 5'h10}};
  cmp_t cmps [6] = '{'{cc_pkg::MODE_TOGGLE, 3'h5}, '{cc_pkg::MODE_SET, 3'h6}, '{cc_pkg::MODE_CLEAR, 3'h1},
    '{cc_pkg::MODE_SWI, 3'h0}, '{cc_pkg::MODE_SPECIAL, 3'h0}, '{cc_pkg::MODE_SPECIAL, 3'h0}};

  capture_compare_unit #(.IS_SECOND_UNIT(1'b1)) uut (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wr_data), .i_wr(wr), .i_rd(rd),
    .o_rd_data(rd_data), .i_unit_pin(pins), .o_unit_pin_out(pin_out), .o_unit_pin_oe(pin_oe),
    .i_timer_ext_clk(ext_clk), .i_sleep(sleep), .i_adc_enabled(adc_en), .o_special_event(special),
    .o_adc_start(adc_start), .o_irq_flag(irq_flag), .o_irq_request(irq_req));
  pin_event_model model (.i_clk_sys(clk_sys), .o_pins(pins), .o_ext_clk(ext_clk));

  // Clock and idle inputs
  initial begin
    clk_sys = 1'b0;
    {rst_n, wr, rd, sleep, adc_en, addr, wr_data} = '0;
  end
  always #5 clk_sys = ~clk_sys;
  // Count trigger pulses, one cycle each
  always @(posedge clk_sys) begin
    if (special === 1'b1) spec_cnt++;
    if (adc_start === 1'b1) adc_cnt++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
  endtask
  // One-cycle write, then a quiet cycle
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] dt);
    addr <= a;
    wr_data <= dt;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] dt);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(posedge clk_sys);
    dt = rd_data;
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] x);
    logic [7:0] lo, hi;
    bus_rd(a, lo);
    bus_rd(a + 4'h1, hi);
    x = {hi, lo};
  endtask
  // Run the time base a while, stop it and read the held count
  task automatic freeze(input int run, output logic [15:0] x);
    bus_wr(cc_pkg::OFF_TMR_CTRL, 8'h01);
    repeat (run) @(posedge clk_sys);
    bus_wr(cc_pkg::OFF_TMR_CTRL, 8'h00);
    rd16(cc_pkg::OFF_TMR_LO, x);
  endtask
  // Off first, then the new mode, then drop any false flag
  task automatic set_mode(input logic [3:0] m);
    bus_wr(cc_pkg::OFF_CTRL, 8'h00);
    bus_wr(cc_pkg::OFF_CTRL, {4'h0, m});
    repeat (4) @(posedge clk_sys);
    bus_wr(cc_pkg::OFF_IRQ_FLAG, 8'h00);
  endtask
  // Bounded wait for the flag; a miss ends the run
  task automatic wait_flag();
    for (int k = 0; k < 300; k++) begin
      @(posedge clk_sys);
      if (irq_flag === 1'b1) return;
    end
    failures++;
    $display("[ERR] %0t flag wait got %h exp %h", $time, 1'b0, 1'b1);
    end_of_test();
  endtask

  initial begin
    reset_dut();
    for (int a = 0; a < 9; a++) begin
      bus_rd(4'(a), b);
      chk(16'(b), 16'h0000);
    end
    foreach (rows[i]) begin
      bus_wr(rows[i].a, rows[i].d);
      bus_rd(rows[i].a, b);
      chk(16'(b), 16'(rows[i].e));
    end
    // Each capture mode: edges short of an event, then the event
    foreach (caps[i]) begin
      model.drive(1'b0);
      freeze(20 + 8 * i, c);
      set_mode(caps[i].m);
      model.rises(int'(caps[i].n) - 1);
      chk(16'(irq_flag), 16'h0000);
      if (caps[i].m == cc_pkg::MODE_FALL) model.drive(1'b0);
      else model.rises(1);
      wait_flag();
      rd16(cc_pkg::OFF_VALUE_LO, v);
      chk(v, c);
    end
    bus_wr(cc_pkg::OFF_IRQ_EN, 8'h01);
    chk(16'(irq_req), 16'h0001);
    bus_wr(cc_pkg::OFF_IRQ_FLAG, 8'h00);
    chk(16'(irq_req), 16'h0000);
    bus_wr(cc_pkg::OFF_IRQ_EN, 8'h00);
    // Direct prescaler switch keeps the count
    set_mode(cc_pkg::MODE_RISE16);
    model.rises(3);
    bus_wr(cc_pkg::OFF_CTRL, {4'h0, cc_pkg::MODE_RISE4});
    bus_wr(cc_pkg::OFF_IRQ_FLAG, 8'h00);
    model.rises(1);
    wait_flag();
    // Reset, then unit off, must both clear a part count
    for (int j = 0; j < 2; j++) begin
      set_mode(cc_pkg::MODE_RISE4);
      model.rises(3);
      if (j == 0) reset_dut();
      set_mode(cc_pkg::MODE_RISE4);
      model.rises(3);
      chk(16'(irq_flag), 16'h0000);
      model.rises(1);
      wait_flag();
    end
    // Sleep halts the instruction clocked count, external keeps going
    freeze(30, c);
    sleep <= 1'b1;
    freeze(30, d);
    chk(d, c);
    sleep <= 1'b0;
    freeze(30, d);
    chk(16'(d != c), 16'h0001);
    bus_wr(cc_pkg::OFF_TMR_CTRL, 8'h03);
    sleep <= 1'b1;
    model.ext_pulses(5);
    set_mode(cc_pkg::MODE_RISE);
    model.rises(1);
    wait_flag();
    rd16(cc_pkg::OFF_VALUE_LO, v);
    chk(v, d + 16'h0005);
    sleep <= 1'b0;
    // Compare modes, match eight ticks ahead
    bus_wr(cc_pkg::OFF_CTRL, 8'h00);
    foreach (cmps[i]) begin
      adc_en <= (i < 5);  // Last trigger runs with the converter off
      bus_wr(cc_pkg::OFF_PIN_SEL, {7'h00, i == 1});  // Set mode drives the alternate pin
      freeze(10, c);
      v = c + 16'h0008;
      bus_wr(cc_pkg::OFF_VALUE_LO, v[7:0]);
      bus_wr(cc_pkg::OFF_VALUE_HI, v[15:8]);
      bus_wr(cc_pkg::OFF_CTRL, {4'h0, cmps[i].m});
      bus_wr(cc_pkg::OFF_IRQ_FLAG, 8'h00);
      bus_wr(cc_pkg::OFF_TMR_CTRL, 8'h01);
      wait_flag();
      repeat (2) @(posedge clk_sys);
      chk(16'({pin_out, pin_oe}), 16'(cmps[i].e));
    end
    freeze(4, d);
    chk(16'(d < 16'h0008), 16'h0001);
    chk(16'(spec_cnt), 16'h0002);
    chk(16'(adc_cnt), 16'h0001);
    end_of_test();
  end
endmodule
`default_nettype wire
